// File: hdl/swg_pkg.sv
// Constants for the standalone timeout guard: register map, fields, timing.
// Assumes an APB master on pclk at 250 MHz and word-aligned registers.
//
// Contract
// - Writing one to restart bit clears counter, starts new period.
// - Restart bit is write-only and always reads as zero.
// - End of period with reset enable set asserts system reset output.
// - Reset enable is write-once after reset, stays set, readable.
// - Rate select readable/writable; one gives 10 ms, zero 20 ms.
// - Reset clears every control bit: disabled, slow rate.
// - With reset enable clear the guard is fully switched off.
// - Counting only in run mode; halts in stop mode, then resumes.
package swg_pkg;
    // ========================================================
    // Register map
    localparam int unsigned CTRL_INDEX     = 32'h0000000A;
    localparam logic [11:0] CTRL_ADDR      = 12'(CTRL_INDEX * 4);
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam int unsigned RESTART_BIT    = 5;
    localparam int unsigned ENABLE_BIT     = 4;
    localparam int unsigned RATE_BIT       = 0;
    // ========================================================
    // Timing
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned FAST_MS        = 10;
    localparam int unsigned SLOW_MS        = 20;
    localparam int unsigned FAST_CYCLES    = FAST_MS * 1000 * CLK_MHZ;
    localparam int unsigned SLOW_CYCLES    = SLOW_MS * 1000 * CLK_MHZ;
    localparam int unsigned RST_PULSE_CYC  = 16;
    localparam int unsigned CNT_W          = 32;
endpackage

// File: hdl/swg_timeout_guard.sv
// Standalone timeout guard with APB control register.
// Assumes synchronous run_mode input; the guard clears its own control
// register when its reset pulse ends, whatever presetn does.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module swg_timeout_guard
    import swg_pkg::*;
#(
    parameter int unsigned FAST_CNT = FAST_CYCLES,
    parameter int unsigned SLOW_CNT = SLOW_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // System
    input  wire logic        run_mode,
    output logic             sys_reset_n_o
);

    // ========================================================
    // Behaviour notes
    // - One control byte at CTRL_ADDR; upper bus bits read zero.
    // - Reads are captured in the setup phase and stand until the
    //   next setup phase, so the master may take them at access.
    // - Writes land at the access-phase edge with byte lane 0 set.
    // - pready is held high by a flop: every access takes one
    //   access cycle, no wait states.
    // - Unmapped addresses raise pslverr in the access phase; writes
    //   there are dropped and reads return zero.
    // - The counter is held at zero while the guard is disabled,
    //   which stands in for the stopped oscillator.
    // - In stop mode the counter holds its value and resumes
    //   counting once run mode returns.
    // - A restart write clears the counter in the same cycle that
    //   the write lands; a zero in the restart bit does nothing.
    // - On timeout the reset output goes low for a fixed pulse.
    //   The guard fires once, then idles until the pulse ends.
    // - At the end of the pulse the control register returns to
    //   its reset values on its own, so a board that does not
    //   loop the reset output back into presetn still sees the
    //   guard disabled afterwards.
    // - A rate change mid-period takes effect at once; the new
    //   limit is compared against the running count.

    // ========================================================
    // Bus decode
    logic        acc_wr;
    logic        acc_rd;
    logic        hit;
    logic        enable_q;
    logic        rate_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;
    logic        timeout;
    logic [4:0]  pulse_q;
    logic        fired_q;
    logic        pulse_end;

    // Access strobes, single wait-free access phase
    assign hit    = (paddr == CTRL_ADDR);
    assign acc_wr = psel && penable && pwrite && hit && pstrb[0];
    assign acc_rd = psel && !penable && !pwrite;

    // Ready always high, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= psel && !penable && (paddr != CTRL_ADDR);
        end
    end

    // Read data registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (acc_rd) begin
            prdata <= 32'h00000000;
            if (hit) begin
                prdata[ENABLE_BIT] <= enable_q;
                prdata[RATE_BIT]   <= rate_q;
            end
        end
    end

    // ========================================================
    // Control register
    // cleared by reset; timeout reset clears too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= CTRL_RESET[ENABLE_BIT];
            rate_q   <= CTRL_RESET[RATE_BIT];
        end else if (pulse_end) begin
            // own reset pulse returns register to reset values
            enable_q <= CTRL_RESET[ENABLE_BIT];
            rate_q   <= CTRL_RESET[RATE_BIT];
        end else if (acc_wr) begin
            // write-once set, never cleared by software
            enable_q <= enable_q | pwdata[ENABLE_BIT];
            rate_q   <= pwdata[RATE_BIT];
        end
    end

    // ========================================================
    // Timeout counter
    assign limit   = rate_q ? CNT_W'(FAST_CNT - 1) : CNT_W'(SLOW_CNT - 1);
    assign timeout = (cnt_q >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (!enable_q) begin
            cnt_q <= '0;
        end else if (acc_wr && pwdata[RESTART_BIT]) begin
            cnt_q <= '0;
        end else if (run_mode && !timeout && !fired_q) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // ========================================================
    // System reset pulse
    // Last cycle of the pulse count; the reset output stays low one cycle more
    assign pulse_end = fired_q && (pulse_q == 5'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fired_q <= 1'b0;
            pulse_q <= '0;
        end else if (enable_q && timeout && !fired_q) begin
            fired_q <= 1'b1;
            pulse_q <= 5'(RST_PULSE_CYC);
        end else if (pulse_end) begin
            // re-arm once the pulse is over
            fired_q <= 1'b0;
            pulse_q <= '0;
        end else if (pulse_q != '0) begin
            pulse_q <= pulse_q - 5'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_n_o <= 1'b1;
        end else begin
            sys_reset_n_o <= !(fired_q && pulse_q != '0) &&
                             !(enable_q && timeout && !fired_q);
        end
    end

    // ========================================================
    // Assertions
    AST_RESTART_CLEARS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_wr && pwdata[RESTART_BIT] && enable_q) |=> (cnt_q == '0))
        else $error("restart did not clear counter");

    AST_RESTART_READS_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> (prdata[RESTART_BIT] == 1'b0))
        else $error("restart bit read back non-zero");

    AST_TIMEOUT_RESET: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable_q && timeout && !fired_q) |=> !sys_reset_n_o)
        else $error("timeout did not assert reset");

    AST_ENABLE_STICKY: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable_q && !pulse_end) |=> enable_q)
        else $error("enable cleared by software");

    AST_RATE_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_wr && !pulse_end) |=> (rate_q == $past(pwdata[RATE_BIT])))
        else $error("rate select not stored");

    AST_OFF_WHEN_DISABLED: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enable_q |=> (cnt_q == '0 && sys_reset_n_o))
        else $error("guard active while disabled");

    AST_STOP_HOLDS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!run_mode && !acc_wr && enable_q) |=> $stable(cnt_q))
        else $error("counter moved in stop mode");

    AST_NO_EARLY_RESET: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!timeout && !fired_q) |=> sys_reset_n_o)
        else $error("reset without timeout");

    // ========================================================
    // Sequences for the reset pulse
    // Trigger: enabled guard reaching end of period
    sequence seq_fire;
        enable_q && timeout && !fired_q;
    endsequence

    // Eight cycles of reset output held low
    sequence seq_low_eight;
        !sys_reset_n_o [*8];
    endsequence

    // Whole pulse: seventeen low cycles, then release
    sequence seq_full_pulse;
        seq_low_eight ##1 seq_low_eight ##1 !sys_reset_n_o
            ##1 sys_reset_n_o;
    endsequence

    AST_PULSE_SHAPE: assert property (
        @(posedge pclk) disable iff (!presetn)
        seq_fire |=> seq_full_pulse)
        else $error("reset pulse has wrong length");

    // Bus never stalls
    AST_PREADY_HIGH: assert property (
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> pready)
        else $error("pready low");

    // Error on unmapped setup
    AST_ERR_UNMAPPED: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !hit) |=> pslverr)
        else $error("no error on unmapped address");

    // No error on mapped setup
    AST_ERR_MAPPED: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit) |=> !pslverr)
        else $error("error on mapped address");

    AST_READ_FIELDS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_rd && hit) |=> (prdata[ENABLE_BIT] == $past(enable_q) &&
                             prdata[RATE_BIT] == $past(rate_q)))
        else $error("read data does not match register");

    // Unmapped reads return zero
    AST_UNMAPPED_READ_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_rd && !hit) |=> (prdata == 32'h00000000))
        else $error("unmapped read not zero");

    AST_ENABLE_SET: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc_wr && pwdata[ENABLE_BIT] && !pulse_end) |=> enable_q)
        else $error("enable write not stored");

    // Writes elsewhere leave register alone
    AST_MISS_NO_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && !hit && !pulse_end) |=>
            ($stable(rate_q) && $stable(enable_q)))
        else $error("write to unmapped address landed");

    AST_COUNT_STEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable_q && run_mode && !timeout && !fired_q && !acc_wr) |=>
            (cnt_q == $past(cnt_q) + CNT_W'(1)))
        else $error("counter did not advance in run mode");

    AST_ZERO_RESTART: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable_q && run_mode && !timeout && !fired_q && acc_wr &&
         !pwdata[RESTART_BIT]) |=> (cnt_q == $past(cnt_q) + CNT_W'(1)))
        else $error("zero restart bit disturbed counter");

    AST_REG_CLEARED: assert property (
        @(posedge pclk) disable iff (!presetn)
        pulse_end |=> (!enable_q && !rate_q && !fired_q))
        else $error("register not cleared after timeout reset");

    AST_FIRE_HOLDS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (fired_q && !pulse_end) |=> fired_q)
        else $error("fired state dropped mid pulse");

    AST_RELEASE: assert property (
        @(posedge pclk) disable iff (!presetn)
        pulse_end |=> (!sys_reset_n_o ##1 sys_reset_n_o))
        else $error("reset output not released after pulse");

endmodule

// File: tb/swg_tb.sv
// Bench for the timeout guard: APB register access and timeout checks.
// Assumes the guard is built with short counts of 20 and 40 cycles.
`timescale 1ns/10ps
module tb;
    import swg_pkg::*;
    // ==========================================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, run_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, sys_reset_n_o, err;
    int          bad_count, n_checks, cyc, n;
    // Guard with shortened periods
    swg_timeout_guard #(.FAST_CNT(20), .SLOW_CNT(40)) swg_timeout_guard_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_mode(run_mode), .sys_reset_n_o(sys_reset_n_o));
    // ==========================================================
    // Clock and hang limit
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end
    // Verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rst();
        presetn <= 0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
    endtask
    // Cycles until the reset output returns high
    task automatic wait_high();
        n = 0;
        while (sys_reset_n_o === 1'b0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // Cycles until the reset output drops
    task automatic wait_low();
        n = 0;
        while (sys_reset_n_o !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        pstrb = 4'hF; run_mode = 1; presetn = 0; cyc = 0;
        rst();
        apb(0, CTRL_ADDR, 0); chk(rd, 32'h00);
        apb(1, CTRL_ADDR, 32'h21); apb(0, CTRL_ADDR, 0); chk(rd, 32'h01);
        apb(1, CTRL_ADDR, 32'h00); apb(0, CTRL_ADDR, 0); chk(rd, 32'h00);
        apb(0, 12'h02C, 0); chk(rd, 32'h00);
        chk({31'h0, err}, 32'h1); chk({31'h0, pready}, 32'h1);
        repeat (60) @(posedge pclk); chk(sys_reset_n_o, 1);
        // Slow period, restarted in time
        apb(1, CTRL_ADDR, 32'h10);
        repeat (3) begin
            apb(1, CTRL_ADDR, 32'h30);
            repeat (30) @(posedge pclk); chk(sys_reset_n_o, 1);
        end
        apb(1, CTRL_ADDR, 32'h30); wait_low();
        chk(n >= 38 && n <= 42, 1);
        wait_high(); chk(n >= 16 && n <= 17, 1);
        apb(0, CTRL_ADDR, 0); chk(rd, 32'h00);
        rst();
        apb(0, CTRL_ADDR, 0); chk(rd, 32'h00);
        // Fast rate, enable cannot be cleared
        apb(1, CTRL_ADDR, 32'h11); apb(0, CTRL_ADDR, 0); chk(rd, 32'h11);
        apb(1, CTRL_ADDR, 32'h01); apb(1, CTRL_ADDR, 32'h00);
        apb(0, CTRL_ADDR, 0); chk(rd, 32'h10);
        apb(1, CTRL_ADDR, 32'h31);
        repeat (10) @(posedge pclk); run_mode <= 0;
        repeat (50) @(posedge pclk); chk(sys_reset_n_o, 1);
        run_mode <= 1; wait_low(); chk(n >= 8 && n <= 13, 1);
        wait_high(); chk(n >= 16 && n <= 17, 1);
        apb(0, CTRL_ADDR, 0); chk(rd, 32'h00);
        rst();
        apb(0, CTRL_ADDR, 0); chk(rd, 32'h00);
        summarize();
    end
endmodule
